// ===== src/ldbuf_regs.sv
// register slice: lock delay, shadow enables, reserved words, shadow stages
// assumes an axi4-lite master, one write and one read outstanding at most
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module ldbuf_regs (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    // axi4-lite write
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // synthesizer core
    input  wire logic        cal_done,
    input  wire logic        qtick_pulse,
    input  wire logic        vtune_ok,
    input  wire logic        update_pulse,
    output logic             lock_detect,
    output logic [15:0]      act_num_lo,
    output logic [15:0]      act_int_div,
    output logic [7:0]       act_ref_div,
    output logic [3:0]       act_ref_mult,
    output logic             act_ref_dbl,
    output logic [2:0]       act_mod_order,
    // interrupt
    output logic             irq
);
    import ldbuf_pkg::*;

    localparam logic [15:0] RST_WORDS [NUM_WORDS] = '{RST_LOCK_DELAY, RST_RSV_A,
        RST_SHADOW_CTRL, RST_RSV_B, RST_RSV_C, RST_RSV_D, RST_RSV_E, RST_RSV_F, RST_RSV_G};

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [15:0]          word_r [NUM_WORDS];
    logic [15:0]          word_nxt [NUM_WORDS];
    logic [31:0]          ctrl_r, ctrl_nxt;
    logic [IRQ_W-1:0]     stat_r, stat_nxt, mask_r, mask_nxt;
    logic [15:0]          pnum_r, pnum_nxt, pint_r, pint_nxt, pref_r, pref_nxt;
    logic [15:0]          pmod_r, pmod_nxt;
    logic [15:0]          anum_r, anum_nxt, aint_r, aint_nxt, aref_r, aref_nxt;
    logic [15:0]          amod_r, amod_nxt;
    logic                 aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
    logic [7:0]           aw_idx_r, aw_idx_nxt;
    logic [31:0]          wd_r, wd_nxt;
    logic [3:0]           ws_r, ws_nxt;
    logic                 bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0]           bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0]          rdata_r, rdata_nxt;
    logic                 lock_prev_r, lock_prev_nxt;
    logic                 do_write, wr_hit, rd_hit, soft_rst, upd;
    logic [7:0]           rd_idx;
    logic [31:0]          merged, rd_val;
    logic [15:0]          sh_ctrl;
    logic                 en_int, lock_w;

    assign sh_ctrl = word_r[2];
    assign en_int  = sh_ctrl[BIT_INT_DIV];

    // ---------------------------------------------------------------
    // axi write channel
    // ---------------------------------------------------------------
    assign s_axi_awready = clk_en && !aw_hold_r && !bvalid_r;
    assign s_axi_wready  = clk_en && !w_hold_r && !bvalid_r;
    assign do_write      = aw_hold_r && w_hold_r && !bvalid_r;
    assign wr_hit        = (aw_idx_r >= IDX_LOCK_DELAY && aw_idx_r <= IDX_RSV_G) ||
                           (aw_idx_r >= IDX_CTRL && aw_idx_r <= IDX_MOD_ORDER);
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            merged[b*8 +: 8] = ws_r[b] ? wd_r[b*8 +: 8] : 8'h00;
        end
    end

    always_comb begin
        aw_hold_nxt = aw_hold_r;
        w_hold_nxt  = w_hold_r;
        aw_idx_nxt  = aw_idx_r;
        wd_nxt      = wd_r;
        ws_nxt      = ws_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_nxt = 1'b1;
            aw_idx_nxt  = s_axi_awaddr[9:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_nxt = 1'b1;
            wd_nxt     = s_axi_wdata;
            ws_nxt     = s_axi_wstrb;
        end
        if (do_write) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // register file and shadow stages
    // ---------------------------------------------------------------
    // soft reset restores the nine words and the control register to their defaults
    assign soft_rst = do_write && aw_idx_r == IDX_CTRL && ws_r[0] && wd_r[CTRL_SWRST_BIT];
    assign upd      = update_pulse ||
                      (do_write && aw_idx_r == IDX_CTRL && ws_r[0] && wd_r[CTRL_UPDATE_BIT]);

    always_comb begin
        for (int i = 0; i < NUM_WORDS; i++) begin
            word_nxt[i] = word_r[i];
            if (do_write && aw_idx_r == IDX_LOCK_DELAY + 8'(i)) begin
                word_nxt[i] = (merged[15:0] & {{8{ws_r[1]}}, {8{ws_r[0]}}}) |
                              (word_r[i] & ~{{8{ws_r[1]}}, {8{ws_r[0]}}});
            end
            if (soft_rst) begin
                word_nxt[i] = RST_WORDS[i];
            end
        end
    end

    always_comb begin
        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;
        pnum_nxt = pnum_r;
        pint_nxt = pint_r;
        pref_nxt = pref_r;
        pmod_nxt = pmod_r;
        if (do_write) begin
            unique case (aw_idx_r)
                IDX_CTRL:      ctrl_nxt = {31'h0000_0000, merged[CTRL_KIND_BIT]};
                IDX_IRQ_MASK:  mask_nxt = merged[IRQ_W-1:0];
                IDX_NUM_LO:    pnum_nxt = merged[15:0];
                IDX_INT_DIV:   pint_nxt = merged[15:0];
                IDX_REF_CFG:   pref_nxt = merged[15:0];
                IDX_MOD_ORDER: pmod_nxt = merged[15:0];
                default:       ;
            endcase
        end
        if (soft_rst) begin
            ctrl_nxt = CTRL_RESET;
        end
        amod_nxt = (!sh_ctrl[BIT_MOD_ORDER] || upd) ? pmod_r : amod_r;
        anum_nxt = (!sh_ctrl[BIT_FRACTION] || upd) ? pnum_r : anum_r;
        aint_nxt = (!en_int || upd) ? pint_r : aint_r;
        aref_nxt[7:0]   = (!(sh_ctrl[BIT_REF_DIVS] && en_int) || upd) ? pref_r[7:0] : aref_r[7:0];
        aref_nxt[11:8]  = (!(sh_ctrl[BIT_REF_MULT] && en_int) || upd) ? pref_r[11:8] : aref_r[11:8];
        aref_nxt[12]    = (!(sh_ctrl[BIT_REF_DBL] && en_int) || upd) ? pref_r[12] : aref_r[12];
        aref_nxt[15:13] = 3'h0;
    end

    // ---------------------------------------------------------------
    // interrupts
    // ---------------------------------------------------------------
    always_comb begin
        lock_prev_nxt = lock_w;
        stat_nxt      = stat_r;
        if (do_write && aw_idx_r == IDX_IRQ_STAT) begin
            stat_nxt = stat_r & ~merged[IRQ_W-1:0];
        end
        if (lock_w && !lock_prev_r) stat_nxt[IRQ_LOCK_RISE] = 1'b1;
        if (!lock_w && lock_prev_r) stat_nxt[IRQ_LOCK_FALL] = 1'b1;
        if (upd) stat_nxt[IRQ_UPDATE] = 1'b1;
    end
    assign irq = |(stat_r & mask_r);

    // ---------------------------------------------------------------
    // axi read channel
    // ---------------------------------------------------------------
    assign s_axi_arready = clk_en && !rvalid_r;
    assign rd_idx        = s_axi_araddr[9:2];
    always_comb begin
        rd_hit = 1'b1;
        rd_val = 32'h0000_0000;
        if (rd_idx >= IDX_LOCK_DELAY && rd_idx <= IDX_RSV_G) begin
            rd_val = {16'h0000, word_r[4'(rd_idx - IDX_LOCK_DELAY)]};
        end else begin
            unique case (rd_idx)
                IDX_CTRL:      rd_val = ctrl_r;
                IDX_IRQ_STAT:  rd_val = {29'h0000_0000, stat_r};
                IDX_IRQ_MASK:  rd_val = {29'h0000_0000, mask_r};
                IDX_STATUS:    rd_val = {31'h0000_0000, lock_w};
                IDX_NUM_LO:    rd_val = {16'h0000, pnum_r};
                IDX_INT_DIV:   rd_val = {16'h0000, pint_r};
                IDX_REF_CFG:   rd_val = {16'h0000, pref_r};
                IDX_MOD_ORDER: rd_val = {16'h0000, pmod_r};
                default:       rd_hit = 1'b0;
            endcase
        end
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = rd_val;
            rresp_nxt  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_WORDS; i++) word_r[i] <= RST_WORDS[i];
            ctrl_r      <= CTRL_RESET;
            mask_r      <= '0;
            stat_r      <= '0;
            {pnum_r, pint_r, pref_r, pmod_r} <= '0;
            {anum_r, aint_r, aref_r, amod_r} <= '0;
            aw_hold_r   <= 1'b0;
            w_hold_r    <= 1'b0;
            aw_idx_r    <= 8'h00;
            wd_r        <= 32'h0000_0000;
            ws_r        <= 4'h0;
            bvalid_r    <= 1'b0;
            bresp_r     <= RESP_OKAY;
            rvalid_r    <= 1'b0;
            rdata_r     <= 32'h0000_0000;
            rresp_r     <= RESP_OKAY;
            lock_prev_r <= 1'b0;
        end else if (clk_en) begin
            for (int i = 0; i < NUM_WORDS; i++) word_r[i] <= word_nxt[i];
            ctrl_r      <= ctrl_nxt;
            mask_r      <= mask_nxt;
            stat_r      <= stat_nxt;
            {pnum_r, pint_r, pref_r, pmod_r} <= {pnum_nxt, pint_nxt, pref_nxt, pmod_nxt};
            {anum_r, aint_r, aref_r, amod_r} <= {anum_nxt, aint_nxt, aref_nxt, amod_nxt};
            aw_hold_r   <= aw_hold_nxt;
            w_hold_r    <= w_hold_nxt;
            aw_idx_r    <= aw_idx_nxt;
            wd_r        <= wd_nxt;
            ws_r        <= ws_nxt;
            bvalid_r    <= bvalid_nxt;
            bresp_r     <= bresp_nxt;
            rvalid_r    <= rvalid_nxt;
            rdata_r     <= rdata_nxt;
            rresp_r     <= rresp_nxt;
            lock_prev_r <= lock_prev_nxt;
        end
    end

    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign act_num_lo    = anum_r;
    assign act_int_div   = aint_r;
    assign act_ref_div   = aref_r[7:0];
    assign act_ref_mult  = aref_r[11:8];
    assign act_ref_dbl   = aref_r[12];
    assign act_mod_order = amod_r[2:0];

    // ---------------------------------------------------------------
    // lock delay timer
    // ---------------------------------------------------------------
    // lock detect
    ldbuf_lock_timer u_timer (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .clk_en      (clk_en),
        .cal_done    (cal_done),
        .qtick_pulse (qtick_pulse),
        .delay_count (word_r[0]),
        .detect_kind (ctrl_r[CTRL_KIND_BIT]),
        .vtune_ok    (vtune_ok),
        .lock_detect (lock_w)
    );
    assign lock_detect = lock_w;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence held_cycle_s;
        clk_en && !upd;
    endsequence
    numer_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (held_cycle_s and sh_ctrl[BIT_FRACTION]) |=> $stable(anum_r))
        else $error("numerator changed without update");
    order_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (held_cycle_s and sh_ctrl[BIT_MOD_ORDER]) |=> $stable(amod_r))
        else $error("order changed without update");
    intdiv_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (held_cycle_s and en_int) |=> $stable(aint_r))
        else $error("int divider changed without update");
    refdiv_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (held_cycle_s and sh_ctrl[BIT_REF_DIVS] && en_int) |=> $stable(aref_r[7:0]))
        else $error("ref dividers changed without update");
    refmult_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (clk_en && !en_int) |=> (aref_r[11:8] == $past(pref_r[11:8])))
        else $error("multiplier shadowed without bit 13");
    refdbl_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (clk_en && !en_int) |=> (aref_r[12] == $past(pref_r[12])))
        else $error("doubler shadowed without bit 13");
    apply_now_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (clk_en && upd) |=> (anum_r == $past(pnum_r)))
        else $error("update did not apply numerator");
    swrst_restore_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (clk_en && soft_rst) |=> (word_r[4] == RST_RSV_C && word_r[2] == RST_SHADOW_CTRL))
        else $error("soft reset did not restore words");
endmodule // ldbuf_regs
`default_nettype wire

// ===== src/ldbuf_pkg.sv
// package for the lock delay and shadow enable register slice
// assumes a 32-bit axi4-lite slave with word-indexed registers
package ldbuf_pkg;
    // register indices (byte address = 4 * index)
    localparam logic [7:0]  IDX_LOCK_DELAY  = 8'h3C;
    localparam logic [7:0]  IDX_RSV_A       = 8'h3D;
    localparam logic [7:0]  IDX_SHADOW_CTRL = 8'h3E;
    localparam logic [7:0]  IDX_RSV_B       = 8'h3F;
    localparam logic [7:0]  IDX_RSV_C       = 8'h40;
    localparam logic [7:0]  IDX_RSV_D       = 8'h41;
    localparam logic [7:0]  IDX_RSV_E       = 8'h42;
    localparam logic [7:0]  IDX_RSV_F       = 8'h43;
    localparam logic [7:0]  IDX_RSV_G       = 8'h44;
    localparam logic [7:0]  IDX_CTRL        = 8'h50;
    localparam logic [7:0]  IDX_IRQ_STAT    = 8'h51;
    localparam logic [7:0]  IDX_IRQ_MASK    = 8'h52;
    localparam logic [7:0]  IDX_STATUS      = 8'h53;
    localparam logic [7:0]  IDX_NUM_LO      = 8'h54;
    localparam logic [7:0]  IDX_INT_DIV     = 8'h55;
    localparam logic [7:0]  IDX_REF_CFG     = 8'h56;
    localparam logic [7:0]  IDX_MOD_ORDER   = 8'h57;
    localparam int          NUM_WORDS       = 9;
    localparam int          NUM_SHADOW      = 6;
    // reset values
    localparam logic [15:0] RST_LOCK_DELAY  = 16'h03E8;
    localparam logic [15:0] RST_RSV_A       = 16'h00A8;
    localparam logic [15:0] RST_SHADOW_CTRL = 16'h00AF;
    localparam logic [15:0] RST_RSV_B       = 16'h0000;
    localparam logic [15:0] RST_RSV_C       = 16'h1388;
    localparam logic [15:0] RST_RSV_D       = 16'h0000;
    localparam logic [15:0] RST_RSV_E       = 16'h01F4;
    localparam logic [15:0] RST_RSV_F       = 16'h0000;
    localparam logic [15:0] RST_RSV_G       = 16'h03E8;
    // shadow enable bit positions
    localparam int          BIT_MOD_ORDER   = 15;
    localparam int          BIT_FRACTION    = 14;
    localparam int          BIT_INT_DIV     = 13;
    localparam int          BIT_REF_DIVS    = 12;
    localparam int          BIT_REF_MULT    = 11;
    localparam int          BIT_REF_DBL     = 10;
    // control register bits
    localparam int          CTRL_KIND_BIT   = 0;
    localparam int          CTRL_UPDATE_BIT = 1;
    localparam int          CTRL_SWRST_BIT  = 2;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;
    // interrupt status bits
    localparam int          IRQ_LOCK_RISE   = 0;
    localparam int          IRQ_LOCK_FALL   = 1;
    localparam int          IRQ_UPDATE      = 2;
    localparam int          IRQ_W           = 3;
    // axi responses
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;
    // lock delay counter states
    typedef enum logic [1:0] {
        LDBUF_IDLE  = 2'b00,
        LDBUF_COUNT = 2'b01,
        LDBUF_DONE  = 2'b10
    } ldbuf_state_t;
endpackage

// ===== src/ldbuf_lock_timer.sv
// lock delay timer: counts quarter pfd ticks after calibration ends
// assumes qtick_pulse is a one-cycle pulse in the aclk domain
`timescale 1ns/1ps
`default_nettype none
module ldbuf_lock_timer (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    // control
    input  wire logic        cal_done,
    input  wire logic        qtick_pulse,
    input  wire logic [15:0] delay_count,
    input  wire logic        detect_kind,
    input  wire logic        vtune_ok,
    // result
    output logic             lock_detect
);
    import ldbuf_pkg::*;

    ldbuf_state_t state_r, state_nxt;
    logic [15:0]  cnt_r, cnt_nxt;
    logic         lock_r, lock_nxt;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        unique case (state_r)
            LDBUF_IDLE: begin
                cnt_nxt = 16'h0000;
                if (cal_done) begin
                    state_nxt = (delay_count == 16'h0000) ? LDBUF_DONE : LDBUF_COUNT;
                end
            end
            LDBUF_COUNT: begin
                if (!cal_done) begin
                    state_nxt = LDBUF_IDLE;
                end else if (qtick_pulse) begin
                    cnt_nxt = cnt_r + 16'h0001;
                    if (cnt_nxt >= delay_count) begin
                        state_nxt = LDBUF_DONE;
                    end
                end
            end
            LDBUF_DONE: begin
                if (!cal_done) begin
                    state_nxt = LDBUF_IDLE;
                end
            end
            default: state_nxt = LDBUF_IDLE;
        endcase
        lock_nxt = (state_nxt == LDBUF_DONE) && (!detect_kind || vtune_ok);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= LDBUF_IDLE;
            cnt_r   <= 16'h0000;
            lock_r  <= 1'b0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            lock_r  <= lock_nxt;
        end
    end

    assign lock_detect = lock_r;

    lock_needs_cal_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(lock_r) |-> $past(cal_done))
        else $error("lock rose without calibration");
    vtune_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (clk_en && $past(clk_en) && lock_r && $past(detect_kind)) |-> $past(vtune_ok))
        else $error("lock high with bad vtune");
endmodule // ldbuf_lock_timer
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the lock delay and shadow enable register slice
// assumes ldbuf_regs with its own assertions inside, driven over axi4-lite
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ldbuf_pkg::*;
    logic aclk, aresetn, clk_en, cal_done, qtick_pulse, vtune_ok, update_pulse;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, lock_detect, irq, act_ref_dbl;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [15:0] act_num_lo, act_int_div, rd;
    logic [7:0] act_ref_div;
    logic [3:0] act_ref_mult;
    logic [2:0] act_mod_order;
    int err_count, check_count;
    logic [7:0] ix [9] = '{IDX_LOCK_DELAY, IDX_RSV_A, IDX_SHADOW_CTRL, IDX_RSV_B, IDX_RSV_C,
                           IDX_RSV_D, IDX_RSV_E, IDX_RSV_F, IDX_RSV_G};
    logic [15:0] rv [9] = '{16'h03E8, 16'h00A8, 16'h00AF, 16'h0000, 16'h1388, 16'h0000, 16'h01F4,
                            16'h0000, 16'h03E8};
    logic [7:0] sx [6] = '{IDX_MOD_ORDER, IDX_NUM_LO, IDX_INT_DIV, IDX_REF_CFG, IDX_REF_CFG, IDX_REF_CFG};
    logic [15:0] sv [6] = '{16'h0005, 16'hA5C3, 16'h1234, 16'h0077, 16'h0900, 16'h1000};
    logic [15:0] se [6] = '{16'h0005, 16'hA5C3, 16'h1234, 16'h0077, 16'h0009, 16'h0001};
    ldbuf_regs uut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .cal_done(cal_done), .qtick_pulse(qtick_pulse), .vtune_ok(vtune_ok),
        .update_pulse(update_pulse), .lock_detect(lock_detect), .act_num_lo(act_num_lo),
        .act_int_div(act_int_div), .act_ref_div(act_ref_div), .act_ref_mult(act_ref_mult),
        .act_ref_dbl(act_ref_dbl), .act_mod_order(act_mod_order), .irq(irq));
    // ----------------------------------------
    // clock, tasks
    // ----------------------------------------
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("unexpected %s expected %h seen %h", n, exp, seen);
            err_count++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge aclk);
    endtask
    task automatic wr(input logic [7:0] i, input logic [15:0] d);
        logic pa, pw, ta, tw, dn;
        pa = 1'b1; pw = 1'b1; dn = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= {22'h0, i, 2'b00}; s_axi_wdata <= {16'h0, d};
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        while (!dn) begin
            @(negedge aclk);
            ta = pa & s_axi_awready; tw = pw & s_axi_wready; dn = s_axi_bvalid; rs = s_axi_bresp;
            @(posedge aclk);
            if (ta) begin s_axi_awvalid <= 1'b0; pa = 1'b0; end
            if (tw) begin s_axi_wvalid <= 1'b0; pw = 1'b0; end
            if (dn) s_axi_bready <= 1'b0;
        end
    endtask
    task automatic rdw(input logic [7:0] i);
        logic pa, dn;
        pa = 1'b1; dn = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= {22'h0, i, 2'b00}; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        while (!dn) begin
            @(negedge aclk);
            pa = pa & ~s_axi_arready; dn = s_axi_rvalid; rd = s_axi_rdata[15:0]; rs = s_axi_rresp;
            @(posedge aclk);
            if (!pa) s_axi_arvalid <= 1'b0;
            if (dn) s_axi_rready <= 1'b0;
        end
    endtask
    task automatic pulse(input bit u);
        @(posedge aclk);
        if (u) update_pulse <= 1'b1; else qtick_pulse <= 1'b1;
        @(posedge aclk);
        update_pulse <= 1'b0; qtick_pulse <= 1'b0;
    endtask
    task automatic words_chk();
        for (int k = 0; k < 9; k++) begin
            rdw(ix[k]);
            chk("reg word", {16'h0, rd}, {16'h0, rv[k]});
        end
    endtask
    function automatic logic [15:0] act(input int k);
        case (k)
            0: act = {13'h0, act_mod_order};
            1: act = act_num_lo;
            2: act = act_int_div;
            3: act = {8'h0, act_ref_div};
            4: act = {12'h0, act_ref_mult};
            default: act = {15'h0, act_ref_dbl};
        endcase
    endfunction
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        end_sim();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {aresetn, cal_done, qtick_pulse, vtune_ok, update_pulse, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        clk_en = 1'b1; s_axi_wstrb = 4'hF; err_count = 0; check_count = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        words_chk();
        rdw(8'h45); chk("unmapped read", {rs, rd}, {RESP_SLVERR, 16'h0});
        wr(8'h45, 16'h1234); chk("unmapped write", rs, RESP_SLVERR);
        wr(IDX_LOCK_DELAY, 16'h0002); wr(IDX_CTRL, 16'h0000); wr(IDX_IRQ_MASK, 16'h0001);
        cal_done <= 1'b1; pulse(0); cyc(3);
        chk("lock early", lock_detect, 1'b0);
        pulse(0); cyc(2);
        chk("lock after delay", lock_detect, 1'b1);
        chk("irq on lock", irq, 1'b1);
        rdw(IDX_IRQ_STAT); chk("irq status", rd, 16'h0001);
        wr(IDX_CTRL, 16'h0001); cyc(3);
        chk("lock no vtune", lock_detect, 1'b0);
        @(posedge aclk);
        vtune_ok <= 1'b1; cyc(3);
        chk("lock with vtune", lock_detect, 1'b1);
        rdw(IDX_STATUS); chk("status lock", rd, 16'h0001);
        wr(IDX_IRQ_MASK, 16'h0000); cyc(2); chk("irq masked", irq, 1'b0);
        wr(IDX_IRQ_MASK, 16'h0001); cyc(2); chk("irq unmasked", irq, 1'b1);
        wr(IDX_IRQ_STAT, 16'h0007); cyc(2); chk("irq cleared", irq, 1'b0);
        for (int k = 0; k < 6; k++) begin
            wr(IDX_SHADOW_CTRL, 16'h00AF); wr(sx[k], 16'h0000); cyc(2);
            chk("act direct", act(k), 16'h0);
            if (k > 2) begin
                wr(IDX_SHADOW_CTRL, 16'h00AF | (16'h0001 << (15 - k))); wr(sx[k], sv[k]); cyc(2);
                chk("act gated", act(k), se[k]);
                wr(sx[k], 16'h0000);
            end
            wr(IDX_SHADOW_CTRL, 16'h20AF | (16'h0001 << (15 - k))); wr(sx[k], sv[k]); cyc(2);
            chk("act held", act(k), 16'h0);
            if (k % 2) pulse(1); else wr(IDX_CTRL, 16'h0003);
            cyc(2);
            chk("act updated", act(k), se[k]);
        end
        wr(IDX_RSV_A, 16'h00A8);
        wr(IDX_RSV_C, 16'h1388);
        wr(IDX_RSV_E, 16'h01F4);
        wr(IDX_RSV_B, 16'h0000);
        wr(IDX_RSV_D, 16'h0000);
        wr(IDX_RSV_F, 16'h0000);
        wr(IDX_RSV_G, 16'h03E8);
        wr(IDX_LOCK_DELAY, 16'h0005);
        s_axi_wstrb <= 4'h1;
        wr(IDX_LOCK_DELAY, 16'hAB77);
        s_axi_wstrb <= 4'hF;
        rdw(IDX_LOCK_DELAY); chk("byte strobe", rd, 16'h0077);
        @(posedge aclk);
        clk_en <= 1'b0; cal_done <= 1'b0; cyc(3);
        chk("lock frozen", lock_detect, 1'b1);
        chk("ready frozen", {s_axi_awready, s_axi_arready}, 2'b00);
        @(posedge aclk);
        clk_en <= 1'b1; cyc(2);
        chk("lock drops", lock_detect, 1'b0);
        wr(IDX_CTRL, 16'h0004); cyc(2);
        words_chk();
        rdw(IDX_CTRL); chk("ctrl after soft reset", rd, 16'h0001);
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
